// >>> bench/tmc_control_tb.sv
// Purpose: self-checking bench of tmc_control
// Assumes: ready count cut to 20 cycles
// Notes:   ranging results compared against a queue model
`timescale 1ns/1ps
module tmc_control_tb;
	localparam [7:0] PART = 8'h5a;	// arbitrary value
	localparam [7:0] VERS = 8'h01;	// arbitrary value
	reg        clk = 1'b0, rst = 1'b1;
	reg        analog_power_threshold = 1'b0, digital_power_threshold = 1'b0;
	reg [7:0]  nv_config_a = 8'h80, nv_config_b = 8'h00, nv_config_c = 8'h00;
	reg [7:0]  nv_addr_sel = 8'hb4, nv_fault_en_a = 8'h00, nv_fault_en_w = 8'h00;
	reg [5:0]  rx_shift = 6'h00;
	reg [1:0]  crossover_off = 2'h0, fine_strobe = 2'h0, coarse_strobe = 2'h0;
	reg [1:0]  dac_lut_mode = 2'h0, loss_input_pin = 2'h0, loss_quick_trip = 2'h0;
	reg [31:0] fine_data = 32'h0, coarse_data = 32'h0, seed = 32'h9be0;
	reg        temp_strobe = 1'b0, lut_wr = 1'b0, lut_sel = 1'b0;
	reg        general_input_pin = 1'b0, rate_select_input = 1'b0;
	reg [15:0] temp_value = 16'h0000;
	reg [7:0]  lut_addr = 8'h00, lut_wdata = 8'h00, alarm_in = 8'h00, warn_in = 8'h00, rv;
	reg [3:0]  other_quick_trip = 4'h0;
	reg [1:0]  st = 2'h0;
	reg [17:0] rq [$];
	wire [7:0] reg_addr, reg_wdata, reg_rdata_r, bus_address_r;
	wire       reg_wr, reg_rd, general_output_pin_o, general_output_pin_oe;
	wire       rate_select_output_o, rate_select_output_oe, fault_r;
	wire [1:0] coarse_req_r, result_strobe_r, result_coarse_r, dac_stream_r;
	wire [1:0] loss_output_pin_o, loss_output_pin_oe;
	wire [31:0] result_data_r;
	wire [19:0] dac_code_r;
	integer    mismatches = 0, tests_run = 0, i, n, m, ones;

	always #25 clk = ~clk;
	tmc_control #(.DIE_PART(PART), .DIE_VERSION(VERS), .READY_CYCLES(20)) u_dut (.*);
	tmc_host_model u_host (.*);

	// ----
	// helpers
	// ----
	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task chk(input [31:0] got, input [31:0] exp);
		begin
			tests_run = tests_run + 1;
			if (got !== exp) begin
				mismatches = mismatches + 1;
				$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task summarize;
		begin
			$display("comparisons %0d mismatches %0d", tests_run, mismatches);
			if (mismatches == 0 && tests_run > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	task w(input integer c);
		repeat (c) @(posedge clk);
	endtask
	task rdchk(input [7:0] a, input [7:0] e);
		begin
			u_host.rd(a, rv);
			chk(rv, e);
		end
	endtask
	// bounded: a stuck flag ends the run
	task wait_rdy;
		begin
			rv = 8'h01;
			for (n = 0; n < 15 && rv[0] !== 1'b0; n = n + 1)
				u_host.rd(8'h6e, rv);
			chk(rv[0], 1'b0);
			if (rv[0] !== 1'b0)
				summarize;
		end
	endtask
	task lw(input [7:0] a, input [7:0] d);
		begin
			@(posedge clk);
			lut_addr <= a;
			lut_wdata <= d;
			lut_wr <= 1'b1;
			@(posedge clk);
			lut_wr <= 1'b0;
		end
	endtask
	task tconv(input [7:0] t, input [9:0] e);
		begin
			@(posedge clk);
			temp_value <= {t, 8'h00};
			temp_strobe <= 1'b1;
			@(posedge clk);
			temp_strobe <= 1'b0;
			@(negedge clk);
			chk(dac_code_r[9:0], e);
		end
	endtask
	// model of ranging: fine first, hysteresis on the way back
	task conv(input integer ch, input [15:0] f);
		integer sh;
		reg [15:0] s, c;
		begin
			sh = rx_shift[3*ch +: 3];
			s = f >> sh;
			seed = lfsr(seed);
			c = seed[15:0];
			st[ch] = crossover_off[ch] && (s > (16'hfff8 >> sh) || st[ch] && s >= (16'hf000 >> sh));
			@(posedge clk);
			fine_strobe[ch] <= 1'b1;
			fine_data[16*ch +: 16] <= f;
			@(posedge clk);
			fine_strobe[ch] <= 1'b0;
			if (st[ch]) begin
				@(negedge clk);
				chk(coarse_req_r[ch], 1'b1);
				@(posedge clk);
				coarse_strobe[ch] <= 1'b1;
				coarse_data[16*ch +: 16] <= c;
				rq.push_back({ch[0], 1'b1, ((c >> sh) < (16'hf000 >> sh)) ? (16'hf000 >> sh) : (c >> sh)});
				@(posedge clk);
				coarse_strobe[ch] <= 1'b0;
			end else
				rq.push_back({ch[0], 1'b0, s});
			w(2);
		end
	endtask
	always @(posedge clk)
		for (m = 0; m < 2; m = m + 1)
			if (result_strobe_r[m] === 1'b1)
				chk({m[0], result_coarse_r[m], result_data_r[16*m +: 16]}, rq.pop_front());

	// ----
	// sequence
	// ----
	initial begin
		w(12);
		rst <= 1'b0;
		w(2);
		rdchk(8'h88, 8'h00);
		rdchk(8'h6e, 8'h01);
		chk(bus_address_r, 8'ha2);
		chk({fault_r, loss_output_pin_oe, general_output_pin_oe, rate_select_output_oe}, 5'h00);
		w(1);
		analog_power_threshold <= 1'b1;
		digital_power_threshold <= 1'b1;
		wait_rdy;
		chk(bus_address_r, 8'hb4);
		rdchk(8'h88, 8'h80);
		u_host.wr(8'h86, 8'h33);
		rdchk(8'h86, PART);
		rdchk(8'h87, VERS);
		rdchk(8'h00, 8'h00);
		for (i = 0; i < 6; i = i + 1) begin
			seed = lfsr(seed);
			u_host.wr(8'(48'h88898a8bf8fc >> (8 * i)), seed[7:0]);
			rdchk(8'(48'h88898a8bf8fc >> (8 * i)), seed[7:0]);
		end
		for (i = 0; i < 16; i = i + 1) begin
			u_host.wr(8'h8a, {4'h0, {2{i[1]}}, {2{i[0]}}});
			loss_input_pin <= {2{i[2]}};
			loss_quick_trip <= {2{i[3]}};
			general_input_pin <= i[1];
			rate_select_input <= i[2];
			w(5);
			n = i[0] ? i[3] : i[2];
			u_host.rd(8'h6e, rv);
			chk({rv[7:6], rv[4:3]}, {i[1], i[2], n[0], n[0]});
			chk(loss_output_pin_oe, {2{~(n[0] ^ i[1])}});
		end
		for (i = 0; i < 2; i = i + 1) begin
			u_host.wr(8'h89, {6'h00, i[0], 1'b1});
			u_host.wr(8'h88, 8'h82);
			u_host.wr(8'h6e, {2'b00, i[0], 5'h00});
			w(3);
			chk({general_output_pin_oe, rate_select_output_oe}, {2{~i[0]}});
		end
		loss_quick_trip <= 2'h0;
		u_host.wr(8'hf8, 8'h01);
		u_host.wr(8'hfc, 8'h00);
		for (i = 0; i < 4; i = i + 1) begin
			u_host.wr(8'h8a, {3'h0, i[1], 4'h0});
			alarm_in <= 8'h01 << i[0];
			w(3);
			chk(fault_r, !i[0]);
			alarm_in <= 8'h00;
			w(3);
			chk(fault_r, !i[0] && i[1]);
			u_host.wr(8'h6e, 8'h04);
			w(3);
			chk(fault_r, 1'b0);
		end
		other_quick_trip <= 4'h8;
		w(3);
		chk(fault_r, 1'b1);
		other_quick_trip <= 4'h0;
		crossover_off <= 2'b11;
		for (i = 0; i < 6; i = i + 1) begin
			n = i % 3;
			rx_shift <= {2{n[2:0]}};
			w(1);
			conv(i / 3, 16'hf800);
			conv(i / 3, 16'hffff);
			conv(i / 3, 16'hf800);
			conv(i / 3, 16'h0800);
		end
		crossover_off <= 2'b00;
		w(1);
		conv(0, 16'hffff);
		conv(1, 16'hffff);
		lw(8'haa, 8'h7b);
		lw(8'ha9, 8'h05);
		lw(8'hfc, 8'h2a);
		dac_lut_mode <= 2'b01;
		tconv(8'h2b, 10'h123);
		tconv(8'h29, 10'h0ad);
		ones = 0;
		for (i = 0; i < 1024; i = i + 1) begin
			@(posedge clk);
			ones = ones + dac_stream_r[0];
		end
		chk(ones >= 171 && ones <= 175, 1'b1);
		lw(8'hfc, 8'hff);
		tconv(8'h2b, 10'h3ff);
		u_host.wr(8'h88, 8'h02);
		analog_power_threshold <= 1'b0;
		w(6);
		u_host.rd(8'h6e, rv);
		chk(rv[0], 1'b1);
		chk({loss_output_pin_oe, general_output_pin_oe, rate_select_output_oe, fault_r}, 5'h00);
		w(1);
		analog_power_threshold <= 1'b1;
		wait_rdy;
		rdchk(8'h88, 8'h02);
		w(1);
		digital_power_threshold <= 1'b0;
		analog_power_threshold <= 1'b0;
		w(6);
		chk(bus_address_r, 8'ha2);
		digital_power_threshold <= 1'b1;
		analog_power_threshold <= 1'b1;
		wait_rdy;
		rdchk(8'h88, 8'h80);
		chk(bus_address_r, 8'hb4);
		summarize;
	end
endmodule // tmc_control_tb

bind tmc_control tmc_properties #(.DIE_PART(DIE_PART), .DIE_VERSION(DIE_VERSION)) u_props (.*);

// >>> bench/tmc_host_model.sv
// Purpose: register host in place of the two-wire engine
// Assumes: read data one cycle after the read strobe
// Notes:   idle lines show the inverse of the last value
`timescale 1ns/1ps
module tmc_host_model (
	// clock
	input  logic       clk,
	// register port
	output logic [7:0] reg_addr = 8'h00,
	output logic       reg_wr = 1'b0,
	output logic       reg_rd = 1'b0,
	output logic [7:0] reg_wdata = 8'h00,
	input  logic [7:0] reg_rdata_r
);
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge clk);
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge clk);
			reg_wr <= 1'b0;
			reg_addr <= ~a;
			reg_wdata <= ~d;
		end
	endtask
	task rd(input [7:0] a, output [7:0] d);
		begin
			@(posedge clk);
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge clk);
			reg_rd <= 1'b0;
			reg_addr <= ~a;
			@(negedge clk);
			d = reg_rdata_r;
		end
	endtask
endmodule // tmc_host_model

// >>> bench/tmc_properties.sv
// Purpose: port assertions of tmc_control
// Assumes: one clock, rst async active high
// Notes:   bound in from the bench top
`timescale 1ns/1ps
module tmc_properties #(
	parameter [7:0] DIE_PART    = 8'h5a,
	parameter [7:0] DIE_VERSION = 8'h01
) (
	// clock, reset, supply
	input logic        clk,
	input logic        rst,
	input logic        analog_power_threshold,
	input logic        digital_power_threshold,
	// register port
	input logic [7:0]  reg_addr,
	input logic        reg_rd,
	input logic [7:0]  reg_rdata_r,
	input logic [7:0]  bus_address_r,
	// ranging
	input logic [5:0]  rx_shift,
	input logic [1:0]  crossover_off,
	input logic [1:0]  fine_strobe,
	input logic [31:0] fine_data,
	input logic [1:0]  coarse_strobe,
	input logic [1:0]  coarse_req_r,
	input logic [1:0]  result_strobe_r,
	input logic [1:0]  result_coarse_r,
	input logic [31:0] result_data_r,
	// lookup, pins, fault
	input logic        temp_strobe,
	input logic [19:0] dac_code_r,
	input logic [1:0]  loss_output_pin_oe,
	input logic        general_output_pin_oe,
	input logic [3:0]  other_quick_trip,
	input logic        fault_r
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire [15:0] fine_sh = fine_data[15:0] >> rx_shift[2:0];
	// margin covers the two sync stages and the recall edge
	sequence up_s; (analog_power_threshold && digital_power_threshold)[*8]; endsequence
	sequence down_s; (!analog_power_threshold)[*5]; endsequence
	sequence coarse_done_s; coarse_req_r[0] ##[1:30] coarse_strobe[0]; endsequence
	// ----
	// assertions
	// ----
	part_code_a: assert property (reg_rd && reg_addr == 8'h86 |=> reg_rdata_r == DIE_PART)
		else $error("part code read wrong");
	die_version_a: assert property (reg_rd && reg_addr == 8'h87 |=> reg_rdata_r == DIE_VERSION)
		else $error("version read wrong");
	outputs_off_a: assert property (down_s |-> !fault_r && !loss_output_pin_oe && !general_output_pin_oe)
		else $error("output active below analog level");
	not_ready_a: assert property (down_s ##0 (reg_rd && reg_addr == 8'h6e) |=> reg_rdata_r[0])
		else $error("not-ready clear below analog level");
	addr_default_a: assert property ((!digital_power_threshold)[*5] |-> bus_address_r == 8'ha2)
		else $error("bus address not default");
	fine_pass_a: assert property (fine_strobe[0] && !crossover_off[0] |=> result_strobe_r[0]
		&& !result_coarse_r[0] && result_data_r[15:0] == $past(fine_sh))
		else $error("fine result wrong");
	coarse_ask_a: assert property (fine_strobe[0] && crossover_off[0]
		&& fine_sh > (16'hfff8 >> rx_shift[2:0]) |=> coarse_req_r[0] && !result_strobe_r[0])
		else $error("coarse conversion not requested");
	coarse_floor_a: assert property (coarse_done_s |=> result_strobe_r[0] && result_coarse_r[0]
		&& result_data_r[15:0] >= (16'hf000 >> rx_shift[2:0]))
		else $error("coarse result below minimum");
	trip_fault_a: assert property (up_s ##0 (other_quick_trip != 4'h0)[*2] |=> fault_r)
		else $error("fault missing on quick trip");
	dac_hold_a: assert property (up_s ##0 !temp_strobe |=> $stable(dac_code_r))
		else $error("output code changed without conversion");
endmodule // tmc_properties

// >>> core/tmc_control.v
// Purpose: control logic of an optical module monitor: ranging, power-up
//          sequencing, lookup-driven delta-sigma outputs, pins, fault, id
// Assumes: byte register port driven by a two-wire engine on clk; ADC core
//          and nonvolatile store are outside
// Notes:   open-drain pins only ever pull low
`timescale 1ns/1ps
`include "tmc_defs.vh"

module tmc_control #(
	parameter [7:0] DIE_PART     = 8'h5a,	// arbitrary value
	parameter [7:0] DIE_VERSION  = 8'h01,	// arbitrary value
	parameter       READY_CYCLES = `TMC_READY_TIME_NS / `TMC_CLK_PERIOD_NS
) (
	// clock and reset
	input  wire        clk,
	input  wire        rst,
	// supply comparators (asynchronous)
	input  wire        analog_power_threshold,
	input  wire        digital_power_threshold,
	// nonvolatile image presented for recall
	input  wire [7:0]  nv_config_a,
	input  wire [7:0]  nv_config_b,
	input  wire [7:0]  nv_config_c,
	input  wire [7:0]  nv_addr_sel,
	input  wire [7:0]  nv_fault_en_a,
	input  wire [7:0]  nv_fault_en_w,
	// register port
	input  wire [7:0]  reg_addr,
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire [7:0]  reg_wdata,
	output reg  [7:0]  reg_rdata_r,
	output reg  [7:0]  bus_address_r,
	// strength channels, two lanes packed
	input  wire [5:0]  rx_shift,
	input  wire [1:0]  crossover_off,
	input  wire [1:0]  fine_strobe,
	input  wire [31:0] fine_data,
	input  wire [1:0]  coarse_strobe,
	input  wire [31:0] coarse_data,
	output reg  [1:0]  coarse_req_r,
	output reg  [1:0]  result_strobe_r,
	output reg  [1:0]  result_coarse_r,
	output reg  [31:0] result_data_r,
	// temperature and lookup tables
	input  wire        temp_strobe,
	input  wire [15:0] temp_value,
	input  wire [1:0]  dac_lut_mode,
	input  wire        lut_wr,
	input  wire        lut_sel,
	input  wire [7:0]  lut_addr,
	input  wire [7:0]  lut_wdata,
	output reg  [19:0] dac_code_r,
	output reg  [1:0]  dac_stream_r,
	// loss of signal
	input  wire [1:0]  loss_input_pin,
	input  wire [1:0]  loss_quick_trip,
	output reg  [1:0]  loss_output_pin_o,
	output reg  [1:0]  loss_output_pin_oe,
	// general and rate-select pins
	input  wire        general_input_pin,
	input  wire        rate_select_input,
	output reg         general_output_pin_o,
	output reg         general_output_pin_oe,
	output reg         rate_select_output_o,
	output reg         rate_select_output_oe,
	// alarms
	input  wire [7:0]  alarm_in,
	input  wire [7:0]  warn_in,
	input  wire [3:0]  other_quick_trip,
	output reg         fault_r
);

	localparam PWR_OFF   = 2'd0;
	localparam PWR_BROWN = 2'd1;
	localparam PWR_RUN   = 2'd2;

	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	reg  [5:0]  meta_r;
	reg  [5:0]  sync_r;
	wire        poa_ok   = sync_r[0];
	wire        pod_ok   = sync_r[1];
	wire [1:0]  loss_pin = sync_r[3:2];
	wire        gen_in   = sync_r[4];
	wire        rate_in  = sync_r[5];

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_r <= 6'h00;
			sync_r <= 6'h00;
		end else begin
			meta_r <= {rate_select_input, general_input_pin, loss_input_pin,
				digital_power_threshold, analog_power_threshold};
			sync_r <= meta_r;
		end
	end

	// ------------------------------------------------------------------
	// power sequencing and shadowed settings
	// ------------------------------------------------------------------
	reg  [1:0]  pwr_r;
	reg         recalled_r;
	reg  [7:0]  cfg_a_r, cfg_b_r, cfg_c_r, addr_sel_r, fen_a_r, fen_w_r;
	reg         rate_soft_r;
	reg  [13:0] rdy_cnt_r;
	reg         not_ready_r;
	wire        run = (pwr_r == PWR_RUN);
	wire        wr_ok = reg_wr & pod_ok & recalled_r;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pwr_r       <= PWR_OFF;
			recalled_r  <= 1'b0;
			cfg_a_r     <= 8'h00;
			cfg_b_r     <= 8'h00;
			cfg_c_r     <= 8'h00;
			addr_sel_r  <= 8'h00;
			fen_a_r     <= 8'h00;
			fen_w_r     <= 8'h00;
			rate_soft_r <= 1'b0;
		end else if (!pod_ok) begin
			pwr_r       <= PWR_OFF;
			recalled_r  <= 1'b0;
			cfg_a_r     <= 8'h00;
			cfg_b_r     <= 8'h00;
			cfg_c_r     <= 8'h00;
			addr_sel_r  <= 8'h00;
			fen_a_r     <= 8'h00;
			fen_w_r     <= 8'h00;
			rate_soft_r <= 1'b0;
		end else begin
			case (pwr_r)
			PWR_OFF: begin
				// shadows stay zero until analog level
				if (poa_ok) begin
					cfg_a_r    <= nv_config_a;
					cfg_b_r    <= nv_config_b;
					cfg_c_r    <= nv_config_c;
					addr_sel_r <= nv_addr_sel;
					fen_a_r    <= nv_fault_en_a;
					fen_w_r    <= nv_fault_en_w;
					recalled_r <= 1'b1;
					pwr_r      <= PWR_RUN;
				end
			end
			PWR_RUN: begin
				if (!poa_ok)
					pwr_r <= PWR_BROWN;
			end
			PWR_BROWN: begin
				if (poa_ok)
					pwr_r <= PWR_RUN;
			end
			default: pwr_r <= PWR_OFF;
			endcase
			if (wr_ok) begin
				case (reg_addr)
				`TMC_OFS_STATUS:     rate_soft_r <= reg_wdata[`TMC_ST_RATE_SOFT];
				`TMC_OFS_CONFIG_A:   cfg_a_r     <= reg_wdata;
				`TMC_OFS_CONFIG_B:   cfg_b_r     <= reg_wdata;
				`TMC_OFS_CONFIG_C:   cfg_c_r     <= reg_wdata;
				`TMC_OFS_ADDR_SEL:   addr_sel_r  <= reg_wdata;
				`TMC_OFS_FAULT_EN_A: fen_a_r     <= reg_wdata;
				`TMC_OFS_FAULT_EN_W: fen_w_r     <= reg_wdata;
				default: ;
				endcase
			end
		end
	end

	// not-ready timer, restarts on every dip
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rdy_cnt_r   <= 14'h0000;
			not_ready_r <= 1'b1;
		end else if (!run) begin
			rdy_cnt_r   <= 14'h0000;
			not_ready_r <= 1'b1;
		end else if (not_ready_r) begin
			rdy_cnt_r <= rdy_cnt_r + 14'h0001;
			if (rdy_cnt_r == READY_CYCLES[13:0] - 14'h0001)
				not_ready_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// strength auto-ranging, one lane per channel
	// ------------------------------------------------------------------
	genvar ch;
	generate
	for (ch = 0; ch < 2; ch = ch + 1) begin : g_rx
		wire [2:0]  sh     = rx_shift[3*ch +: 3];
		// shift applied before compare and storage
		wire [15:0] fine_s = fine_data[16*ch +: 16] >> sh;
		wire [15:0] crs_s  = coarse_data[16*ch +: 16] >> sh;
		wire [15:0] fmax   = `TMC_FINE_MAX_BASE >> sh;
		wire [15:0] cmin   = `TMC_COARSE_MIN_BASE >> sh;
		reg         in_coarse_r;

		always @(posedge clk or posedge rst) begin
			if (rst) begin
				in_coarse_r                <= 1'b0;
				coarse_req_r[ch]           <= 1'b0;
				result_strobe_r[ch]        <= 1'b0;
				result_coarse_r[ch]        <= 1'b0;
				result_data_r[16*ch +: 16] <= 16'h0000;
			end else begin
				coarse_req_r[ch]    <= 1'b0;
				result_strobe_r[ch] <= 1'b0;
				if (fine_strobe[ch]) begin
					// fine first, coarse entered only on overflow
					// hysteresis: leave coarse only below coarse min
					// fine again once it falls below coarse min
					if (crossover_off[ch] &&
					    (in_coarse_r ? (fine_s >= cmin) : (fine_s > fmax))) begin
						in_coarse_r      <= 1'b1;
						coarse_req_r[ch] <= 1'b1;
					end else begin
						in_coarse_r                <= 1'b0;
						result_strobe_r[ch]        <= 1'b1;
						result_coarse_r[ch]        <= 1'b0;
						result_data_r[16*ch +: 16] <= fine_s;
					end
				end else if (coarse_strobe[ch]) begin
					result_strobe_r[ch] <= 1'b1;
					result_coarse_r[ch] <= 1'b1;
					// coarse report clamped to its minimum
					if (crossover_off[ch] && crs_s < cmin)
						result_data_r[16*ch +: 16] <= cmin;
					else
						result_data_r[16*ch +: 16] <= crs_s;
				end
			end
		end
	end
	endgenerate

	// ------------------------------------------------------------------
	// temperature lookup and delta-sigma outputs
	// ------------------------------------------------------------------
	reg  [7:0]  lut_mem [0:511];
	// 2 C steps from the bottom of range
	wire signed [8:0] t_sum = $signed({temp_value[15], temp_value[15:8]}) + `TMC_TEMP_BIAS;
	wire [6:0]  t_half = t_sum[8] ? 7'd0 : t_sum[7:1];
	wire [6:0]  f_idx  = (t_half > `TMC_LUT_FINE_LAST) ? `TMC_LUT_FINE_LAST : t_half;
	wire [6:0]  o_div  = f_idx / `TMC_LUT_OFS_GROUP;
	wire [7:0]  f_addr = `TMC_LUT_FINE_BASE + {1'b0, f_idx};
	wire [7:0]  o_addr = `TMC_LUT_OFS_BASE + {5'h00, o_div[2:0]};

	always @(posedge clk) begin
		if (lut_wr)
			lut_mem[{lut_sel, lut_addr}] <= lut_wdata;
	end

	generate
	for (ch = 0; ch < 2; ch = ch + 1) begin : g_dac
		wire [7:0]  f_val = lut_mem[{ch == 1, f_addr}];
		wire [7:0]  o_val = lut_mem[{ch == 1, o_addr}];
		// table entry plus four times offset
		wire [10:0] sum   = {3'h0, f_val} + {1'b0, o_val, 2'b00};
		wire [10:0] sat   = (sum > `TMC_DAC_MAX) ? `TMC_DAC_MAX : sum;
		reg  [9:0]  acc_r;
		wire [10:0] acc_n = {1'b0, acc_r} + {1'b0, dac_code_r[10*ch +: 10]};

		always @(posedge clk or posedge rst) begin
			if (rst) begin
				dac_code_r[10*ch +: 10] <= 10'h000;
				acc_r                   <= 10'h000;
				dac_stream_r[ch]        <= 1'b0;
			end else begin
				// refresh on each finished temperature reading
				if (temp_strobe && dac_lut_mode[ch])
					dac_code_r[10*ch +: 10] <= sat[9:0];
				if (run) begin
					acc_r            <= acc_n[9:0];
					dac_stream_r[ch] <= acc_n[10];
				end else begin
					acc_r            <= 10'h000;
					dac_stream_r[ch] <= 1'b0;
				end
			end
		end
	end
	endgenerate

	// ------------------------------------------------------------------
	// loss mux, pins and fault
	// ------------------------------------------------------------------
	// selection held at pin source until recall
	wire [1:0] loss_sel = cfg_c_r[`TMC_CC_LOSS_SEL_LO +: 2] & {2{recalled_r}};
	wire [1:0] loss_mux = (loss_sel & loss_quick_trip) | (~loss_sel & loss_pin);
	wire [1:0] loss_lvl = loss_mux ^ cfg_c_r[`TMC_CC_LOSS_INV_LO +: 2];
	// force or invert the general output
	wire       gen_lvl  = (cfg_b_r[`TMC_CB_GEN_FORCE] ? cfg_b_r[`TMC_CB_GEN_VALUE] : gen_in)
		^ cfg_b_r[`TMC_CB_GEN_INV];
	// soft control and inversion of rate select
	wire       rate_lvl = (cfg_a_r[`TMC_CA_RATE_SOFT_EN] ? rate_soft_r : rate_in)
		^ cfg_a_r[`TMC_CA_RATE_INV];
	// masked alarms and warnings; other trips always
	wire [7:0] al_hit = alarm_in & fen_a_r;
	wire [7:0] wn_hit = warn_in & fen_w_r;
	reg  [7:0] al_lat_r;
	reg  [7:0] wn_lat_r;
	wire       clr_fault = wr_ok && reg_addr == `TMC_OFS_STATUS && reg_wdata[`TMC_ST_FAULT];
	wire       fault_any = (|al_lat_r) | (|wn_lat_r) | (|al_hit) | (|wn_hit)
		| (|other_quick_trip);

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			al_lat_r <= 8'h00;
			wn_lat_r <= 8'h00;
		end else begin
			// latch when enabled; set wins over clear
			al_lat_r <= (cfg_c_r[`TMC_CC_LATCH_ALARM] & ~clr_fault ? al_lat_r : 8'h00)
				| (cfg_c_r[`TMC_CC_LATCH_ALARM] ? al_hit : 8'h00);
			wn_lat_r <= (cfg_b_r[`TMC_CB_LATCH_WARN] & ~clr_fault ? wn_lat_r : 8'h00)
				| (cfg_b_r[`TMC_CB_LATCH_WARN] ? wn_hit : 8'h00);
		end
	end

	// open-drain drivers pull low when level is zero; off below analog level
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			loss_output_pin_o     <= 2'b00;
			loss_output_pin_oe    <= 2'b00;
			general_output_pin_o  <= 1'b0;
			general_output_pin_oe <= 1'b0;
			rate_select_output_o  <= 1'b0;
			rate_select_output_oe <= 1'b0;
			fault_r               <= 1'b0;
		end else begin
			loss_output_pin_o     <= 2'b00;
			general_output_pin_o  <= 1'b0;
			rate_select_output_o  <= 1'b0;
			loss_output_pin_oe    <= run ? ~loss_lvl : 2'b00;
			general_output_pin_oe <= run & ~gen_lvl;
			rate_select_output_oe <= run & ~rate_lvl;
			fault_r               <= run & fault_any;
		end
	end

	// ------------------------------------------------------------------
	// read path and bus address
	// ------------------------------------------------------------------
	wire [7:0] status = {gen_in, rate_in, rate_soft_r, loss_mux,
		fault_any, 1'b0, not_ready_r};

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata_r   <= 8'h00;
			bus_address_r <= `TMC_DEFAULT_ADDR;
		end else begin
			// default address until recalled and enabled
			bus_address_r <= (recalled_r && cfg_a_r[`TMC_CA_ADDR_EN])
				? ((addr_sel_r & `TMC_ADDR_BASE_MASK) | (addr_sel_r & `TMC_ADDR_SEL_MASK))
				: `TMC_DEFAULT_ADDR;
			if (reg_rd) begin
				case (reg_addr)
				`TMC_OFS_STATUS:     reg_rdata_r <= status;
				`TMC_OFS_PART:       reg_rdata_r <= DIE_PART;
				`TMC_OFS_VERSION:    reg_rdata_r <= DIE_VERSION;
				`TMC_OFS_CONFIG_A:   reg_rdata_r <= cfg_a_r;
				`TMC_OFS_CONFIG_B:   reg_rdata_r <= cfg_b_r;
				`TMC_OFS_CONFIG_C:   reg_rdata_r <= cfg_c_r;
				`TMC_OFS_ADDR_SEL:   reg_rdata_r <= addr_sel_r;
				`TMC_OFS_FAULT_EN_A: reg_rdata_r <= fen_a_r;
				`TMC_OFS_FAULT_EN_W: reg_rdata_r <= fen_w_r;
				default:             reg_rdata_r <= 8'h00;
				endcase
			end
		end
	end

endmodule // tmc_control

// >>> shared/tmc_defs.vh
// Purpose: constants of the transceiver module control block
// Assumes: 20 MHz core clock, byte-wide register port
// Notes:   definitions only
`ifndef TMC_DEFS_VH
`define TMC_DEFS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define TMC_OFS_STATUS      8'h6e
`define TMC_OFS_PART        8'h86
`define TMC_OFS_VERSION     8'h87
`define TMC_OFS_CONFIG_A    8'h88
`define TMC_OFS_CONFIG_B    8'h89
`define TMC_OFS_CONFIG_C    8'h8a
`define TMC_OFS_ADDR_SEL    8'h8b
`define TMC_OFS_FAULT_EN_A  8'hf8
`define TMC_OFS_FAULT_EN_W  8'hfc

// ----------------------------------------------------------------------
// status_flags bits
// ----------------------------------------------------------------------
`define TMC_ST_NOT_READY    0
`define TMC_ST_FAULT        2
`define TMC_ST_RXLOSS_LO    3
`define TMC_ST_RATE_SOFT    5
`define TMC_ST_RATE_IN      6
`define TMC_ST_GEN_IN       7

// ----------------------------------------------------------------------
// config bits
// ----------------------------------------------------------------------
`define TMC_CA_RATE_INV     0
`define TMC_CA_RATE_SOFT_EN 1
`define TMC_CA_ADDR_EN      7
`define TMC_CB_GEN_FORCE    0
`define TMC_CB_GEN_VALUE    1
`define TMC_CB_GEN_INV      2
`define TMC_CB_LATCH_WARN   4
`define TMC_CC_LOSS_SEL_LO  0
`define TMC_CC_LOSS_INV_LO  2
`define TMC_CC_LATCH_ALARM  4

// ----------------------------------------------------------------------
// values
// ----------------------------------------------------------------------
`define TMC_DEFAULT_ADDR    8'ha2
`define TMC_ADDR_SEL_MASK   8'h0e
`define TMC_ADDR_BASE_MASK  8'hf0
`define TMC_FINE_MAX_BASE   16'hfff8
`define TMC_COARSE_MIN_BASE 16'hf000
`define TMC_LUT_FINE_BASE   8'h80
`define TMC_LUT_OFS_BASE    8'hf8
`define TMC_LUT_FINE_LAST   7'd71
`define TMC_LUT_OFS_GROUP   7'd9
`define TMC_TEMP_BIAS       9'sd41
`define TMC_DAC_MAX         11'h3ff

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define TMC_CLK_PERIOD_NS   50
`define TMC_READY_TIME_NS   500000

`endif
